// ==== bench/awgm_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
// **
// port checks
// **
module awgm_assertions
(
  input wire logic        I_CLOCK, I_RST, I_CH1_VALID, I_CH2_VALID, I_SET_TRIG,
  input wire logic        I_TRIG_DEFER, I_PLAYING, O_TRIG_PENDING,
  input wire logic [15:0] I_CH1_WORD, I_CH2_WORD,
  input wire logic [11:0] I_CONN_SEL,
  input wire logic [3:0]  I_TRIG_VALUE, I_CONN_DRIVE, O_TRIG, O_CONN, O_CONN_OE,
  input wire logic [1:0]  O_MARKER
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  // idle channels add no marker bits
  wire [1:0] mk = (I_CH1_VALID ? I_CH1_WORD[1:0] : 2'h0) | (I_CH2_VALID ? I_CH2_WORD[1:0] : 2'h0);
  sequence s_run; !$past(I_RST) && !$past(I_RST, 2); endsequence
  sequence s_load; !$past(I_RST) && $past(I_SET_TRIG && !(I_TRIG_DEFER && I_PLAYING)); endsequence
  sequence s_defer; I_SET_TRIG && I_TRIG_DEFER && I_PLAYING; endsequence
  marker_or_a: assert property (s_run |-> O_MARKER == $past(mk, 2))
    else $error("marker");
  trig_load_a: assert property (s_load |-> O_TRIG == $past(I_TRIG_VALUE))
    else $error("trig load");
  trig_hold_a: assert property (!$past(I_RST || I_SET_TRIG || O_TRIG_PENDING) |-> $stable(O_TRIG))
    else $error("trig hold");
  defer_wait_a: assert property (s_defer |=> O_TRIG_PENDING && $stable(O_TRIG))
    else $error("defer early");
  defer_end_a: assert property (O_TRIG_PENDING && !I_PLAYING && !I_SET_TRIG |=> !O_TRIG_PENDING)
    else $error("defer stuck");
  drive_en_a: assert property (!$past(I_RST) |-> O_CONN_OE == $past(I_CONN_DRIVE))
    else $error("enable");
  conn_trig_a: assert property (!$past(I_RST) && $past(I_CONN_SEL[5:3]) == 3'h4 |-> O_CONN[1] == $past(O_TRIG[0]))
    else $error("conn source");
  reset_low_a: assert property ($past(I_RST) |-> {O_TRIG, O_MARKER, O_CONN_OE, O_TRIG_PENDING} == 11'h0)
    else $error("reset");
endmodule
bind awgm_top awgm_assertions u_chk (.*);
`default_nettype wire

// ==== bench/awgm_scope_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// **
// far-side instrument
// **
module awgm_scope_model
(
  input  wire logic [3:0] i_conn,
  input  wire logic [3:0] i_oe,
  output logic [3:0]      o_seen
);
  // an undriven connector reads low through its termination
  assign o_seen = i_conn & i_oe;
endmodule
`default_nettype wire

// ==== bench/test_awgm_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// **
// bench
// **
module test_awgm_top;
  logic        clk = 0, rst = 1, v1 = 0, v2 = 0, st = 0, df = 0, pl = 0;
  logic [15:0] w1 = '0, w2 = '0, s1 = '1;
  logic [11:0] sel = '0;
  logic [3:0]  tv = '0, dr = '0;
  logic [1:0]  r1 = 2'h1, r2 = 2'h2;
  wire  [15:0] g1, g2;
  wire  [3:0]  tr, cn, oe, sn;
  wire  [1:0]  mk;
  wire         pd;
  int          errors = 0, cmp_count = 0, cyc = 0;
  always #5 clk = ~clk;
  awgm_top u_dut (.I_CLOCK(clk), .I_RST(rst), .I_CH1_WORD(w1), .I_CH1_VALID(v1), .I_CH2_WORD(w2),
    .I_CH2_VALID(v2), .I_CH1_ROUTE(r1), .I_CH2_ROUTE(r2), .I_CH1_SCALE(s1), .I_CH2_SCALE(16'hFFFF),
    .I_SET_TRIG(st), .I_TRIG_VALUE(tv), .I_TRIG_DEFER(df), .I_PLAYING(pl), .I_CONN_SEL(sel),
    .I_CONN_DRIVE(dr), .O_SIG1(g1), .O_SIG2(g2), .O_MARKER(mk), .O_TRIG(tr), .O_CONN(cn),
    .O_CONN_OE(oe), .O_TRIG_PENDING(pd));
  awgm_scope_model u_far (.i_conn(cn), .i_oe(oe), .o_seen(sn));
  // watchdog, the run needs under 100 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 1000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // inputs move at the falling edge only
  task tk(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task t_mark;
    for (int i = 0; i < 4; i++)
    begin
      w1 = 16'hFFFC | i[15:0]; v1 = 1; tk(2);
      cmp("mark", i[15:0], mk);
    end
    w1 = 16'h1; w2 = 16'h2; v2 = 1; tk(2);
    cmp("mark", 16'h3, mk);
    v1 = 0; v2 = 0; tk(2);
    cmp("mark", 16'h0, mk);
  endtask
  task t_route;
    w1 = 16'hFFFC; v1 = 1; r1 = 2'h2; tk(2);
    cmp("sig1", 16'h8000, g1);
    cmp("sig2", 16'h3, g2[15:14]);
    s1 = '0; tk(2);
    cmp("sig2", 16'h8000, g2);
    // both channels onto output 1: offsets add around midscale
    r1 = 2'h1; r2 = 2'h1; w1 = 16'hA000; w2 = 16'hA000; v2 = 1; s1 = '1; tk(2);
    cmp("sig1", 16'hBFF8, g1);
    cmp("sig2", 16'h8000, g2);
    v2 = 0; r2 = 2'h2;
  endtask
  task t_trig;
    st = 1;
    for (int i = 0; i < 4; i++)
    begin
      tv = 4'h3 << i; tk(1);
      cmp("trig", tv, tr);
    end
    st = 0; tk(4);
    cmp("trig", 16'h8, tr);
    pl = 1; st = 1; df = 1; tv = 4'h5; tk(1);
    st = 0; df = 0; tk(3);
    cmp("pend", 16'h1, pd);
    cmp("trig", 16'h8, tr);
    pl = 0; tk(1);
    cmp("trig", 16'h5, tr);
  endtask
  task t_conn;
    sel = {3'h7, 3'h1, 3'h4, 3'h0}; dr = 4'hF; w1 = 16'h1; tv = 4'h9; st = 1; tk(1);
    st = 0; tk(3);
    cmp("seen", 16'hB, sn);
    dr = 4'h5; tk(2);
    cmp("seen", 16'h1, sn);
  endtask
  // mid-run reset clears triggers, markers and drivers
  task t_reset;
    rst = 1; tk(2);
    cmp("trig", 16'h0, tr);
    cmp("mark", 16'h0, mk);
    cmp("oe", 16'h0, oe);
    cmp("pend", 16'h0, pd);
    rst = 0; tk(1);
    cmp("trig", 16'h0, tr);
  endtask
  task tally_and_finish;
    $display("%0d checks %0d errors", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    tk(8);
    rst = 0; tk(1);
    cmp("sig1", 16'h8000, g1);
    t_mark;
    t_route;
    t_trig;
    t_conn;
    t_reset;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== verilog/awgm_chan_scale.v ====
`timescale 1ns/10ps
`default_nettype none
`include "awgm_map.vh"
module awgm_chan_scale
(
  input  wire                     i_clock,
  input  wire                     i_rst,
  input  wire [`AWGM_WORD_W-1:0]  i_word,
  input  wire                     i_valid,
  input  wire [`AWGM_SCALE_W-1:0] i_scale,
  output reg  [`AWGM_WORD_W-1:0]  o_word
);
  wire signed [13:0] analog_s;
  wire signed [30:0] prod;
  // unsigned code to signed around midscale
  // upper fourteen bits are the amplitude, the low two ride along as markers
  assign analog_s = {~i_word[`AWGM_ANALOG_MSB], i_word[`AWGM_ANALOG_MSB-1:`AWGM_ANALOG_LSB]};
  assign prod = analog_s * $signed({1'b0, i_scale});

  // ****************************************
  // per-channel scaling, markers pass untouched while valid
  // ****************************************
  always @(posedge i_clock)
  begin
    if (i_rst)
      o_word <= 16'h8000;
    else if (i_valid)
      o_word <= {~prod[29], prod[28:16], i_word[`AWGM_MARKER_MSB:`AWGM_MARKER_LSB]};
    else
      o_word <= 16'h8000; // idle midscale, markers zero
  end
endmodule
`default_nettype wire

// ==== verilog/awgm_map.vh ====
`ifndef AWGM_MAP_VH
`define AWGM_MAP_VH
// ****************************************
// sample word layout
// ****************************************
`define AWGM_WORD_W      16
`define AWGM_ANALOG_MSB  15
`define AWGM_ANALOG_LSB  2
`define AWGM_MARKER_MSB  1
`define AWGM_MARKER_LSB  0
`define AWGM_MARKER_W    2
// ****************************************
// trigger, routing and scale
// ****************************************
`define AWGM_TRIG_W      4
`define AWGM_TRIG_RST    4'h0
`define AWGM_SEL_W       3
`define AWGM_ROUTE_OUT1  0
`define AWGM_ROUTE_OUT2  1
`define AWGM_SCALE_W     16
`define AWGM_SCALE_RST   16'hFFFF
`endif

// ==== verilog/awgm_top.v ====
`timescale 1ns/10ps
`default_nettype none
`include "awgm_map.vh"
module awgm_top
(
  input  wire                     I_CLOCK,
  input  wire                     I_RST,
  input  wire [`AWGM_WORD_W-1:0]  I_CH1_WORD,
  input  wire                     I_CH1_VALID,
  input  wire [`AWGM_WORD_W-1:0]  I_CH2_WORD,
  input  wire                     I_CH2_VALID,
  input  wire [1:0]               I_CH1_ROUTE,
  input  wire [1:0]               I_CH2_ROUTE,
  input  wire [`AWGM_SCALE_W-1:0] I_CH1_SCALE,
  input  wire [`AWGM_SCALE_W-1:0] I_CH2_SCALE,
  input  wire                     I_SET_TRIG,
  input  wire [`AWGM_TRIG_W-1:0]  I_TRIG_VALUE,
  input  wire                     I_TRIG_DEFER,
  input  wire                     I_PLAYING,
  input  wire [4*`AWGM_SEL_W-1:0] I_CONN_SEL,
  input  wire [3:0]               I_CONN_DRIVE,
  output reg  [`AWGM_WORD_W-1:0]  O_SIG1,
  output reg  [`AWGM_WORD_W-1:0]  O_SIG2,
  output reg  [1:0]               O_MARKER,
  output reg  [`AWGM_TRIG_W-1:0]  O_TRIG,
  output reg  [3:0]               O_CONN,
  output reg  [3:0]               O_CONN_OE,
  output reg                      O_TRIG_PENDING
);
  wire [`AWGM_WORD_W-1:0] ch1_s;
  wire [`AWGM_WORD_W-1:0] ch2_s;
  reg  [1:0]              r1;
  reg  [1:0]              r2;
  reg  [`AWGM_TRIG_W-1:0] pend_value;
  reg  [`AWGM_WORD_W-1:0] next_sig1;
  reg  [`AWGM_WORD_W-1:0] next_sig2;
  reg  [1:0]              next_marker;
  reg  [3:0]              next_conn;
  integer                 k;

  // ****************************************
  // channel scaling
  // ****************************************
  // channel 1 always takes the first wave, channel 2 the second
  awgm_chan_scale u_ch1
  (
    .i_clock (I_CLOCK),
    .i_rst   (I_RST),
    .i_word  (I_CH1_WORD),
    .i_valid (I_CH1_VALID),
    .i_scale (I_CH1_SCALE),
    .o_word  (ch1_s)
  );
  awgm_chan_scale u_ch2
  (
    .i_clock (I_CLOCK),
    .i_rst   (I_RST),
    .i_word  (I_CH2_WORD),
    .i_valid (I_CH2_VALID),
    .i_scale (I_CH2_SCALE),
    .o_word  (ch2_s)
  );

  // route registered alongside samples so both stay aligned
  always @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      r1 <= 2'h0;
      r2 <= 2'h0;
    end
    else
    begin
      r1 <= I_CH1_VALID ? I_CH1_ROUTE : 2'h0;
      r2 <= I_CH2_VALID ? I_CH2_ROUTE : 2'h0;
    end
  end

  // sum of two unsigned codes, offset removed, saturated
  function [`AWGM_WORD_W-1:0] mix;
    input [`AWGM_WORD_W-1:0] a;
    input                    ua;
    input [`AWGM_WORD_W-1:0] b;
    input                    ub;
    reg signed [17:0] s;
    begin
      s = 18'sd0;
      if (ua)
        s = s + $signed({2'b00, a[15:2], 2'b00}) - 18'sd32768;
      if (ub)
        s = s + $signed({2'b00, b[15:2], 2'b00}) - 18'sd32768;
      s = s + 18'sd32768;
      if (s < 0)
        s = 18'sd0;
      else if (s > 18'sd65532)
        s = 18'sd65532;
      mix = {s[15:2], (ua ? a[1:0] : 2'b00) | (ub ? b[1:0] : 2'b00)};
    end
  endfunction

  // ****************************************
  // output mixing, markers aligned to samples
  // ****************************************
  always @*
  begin
    next_sig1 = mix(ch1_s, r1[`AWGM_ROUTE_OUT1], ch2_s, r2[`AWGM_ROUTE_OUT1]);
    next_sig2 = mix(ch1_s, r1[`AWGM_ROUTE_OUT2], ch2_s, r2[`AWGM_ROUTE_OUT2]);
    // markers taken from the same cycle as the analog word
    next_marker = ch1_s[`AWGM_MARKER_MSB:`AWGM_MARKER_LSB] | ch2_s[`AWGM_MARKER_MSB:`AWGM_MARKER_LSB];
    for (k = 0; k < 4; k = k + 1)
    begin
      case (I_CONN_SEL[k*`AWGM_SEL_W +: `AWGM_SEL_W])
        3'h0: next_conn[k] = next_marker[0];
        3'h1: next_conn[k] = next_marker[1];
        3'h4: next_conn[k] = O_TRIG[0];
        3'h5: next_conn[k] = O_TRIG[1];
        3'h6: next_conn[k] = O_TRIG[2];
        3'h7: next_conn[k] = O_TRIG[3];
        default: next_conn[k] = 1'b0;
      endcase
    end
  end

  always @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      O_SIG1    <= 16'h8000;
      O_SIG2    <= 16'h8000;
      O_MARKER  <= 2'h0;
      O_CONN    <= 4'h0;
      O_CONN_OE <= 4'h0;
    end
    else
    begin
      O_SIG1    <= next_sig1;
      O_SIG2    <= next_sig2;
      O_MARKER  <= next_marker;
      O_CONN    <= next_conn;
      O_CONN_OE <= I_CONN_DRIVE;
    end
  end

  // ****************************************
  // trigger register
  // ****************************************
  // a deferred load waits for playback to end; coarse, command-rate timing
  always @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      O_TRIG         <= `AWGM_TRIG_RST;
      O_TRIG_PENDING <= 1'b0;
      pend_value     <= `AWGM_TRIG_RST;
    end
    else if (I_SET_TRIG && I_TRIG_DEFER && I_PLAYING)
    begin
      O_TRIG_PENDING <= 1'b1;
      pend_value     <= I_TRIG_VALUE;
    end
    else if (I_SET_TRIG)
    begin
      O_TRIG         <= I_TRIG_VALUE; // bit0 drives trigger 1
      O_TRIG_PENDING <= 1'b0;
    end
    else if (O_TRIG_PENDING && !I_PLAYING)
    begin
      O_TRIG         <= pend_value;
      O_TRIG_PENDING <= 1'b0;
    end
  end
endmodule
`default_nettype wire
